/* rtl/accr_pkg.sv */
// Package: register map, field layout and reset values of the channel config bank
package accr_pkg;

  // Register indices (printed offsets are all multiples of four)
  localparam logic [3:0] IDX_THRESHOLD_HIGH = 4'h7;
  localparam logic [3:0] IDX_THRESHOLD_LOW  = 4'h8;
  localparam logic [3:0] IDX_CH0_CONFIG     = 4'h9;
  localparam logic [3:0] IDX_CH0_OFFSET_HI  = 4'ha;
  localparam logic [3:0] IDX_CH0_OFFSET_LO  = 4'hb;
  localparam logic [3:0] IDX_CH0_GAIN_HI    = 4'hc;
  localparam logic [3:0] IDX_CH0_GAIN_LO    = 4'hd;

  // Byte address is four times the index
  localparam int ADDR_W = 8;

  // Reset values
  localparam logic [15:0] RST_THRESHOLD_HIGH = 16'h0000;
  localparam logic [7:0]  RST_THRESHOLD_LOW  = 8'h00;
  localparam logic [3:0]  RST_DC_REMOVAL     = 4'h0;
  localparam logic [9:0]  RST_CH0_DELAY      = 10'h000;
  localparam logic        RST_CH0_DC_OFF     = 1'b0;
  localparam logic [15:0] RST_OFFSET_HIGH    = 16'h0000;
  localparam logic [7:0]  RST_OFFSET_LOW     = 8'h00;
  localparam logic [15:0] RST_GAIN_HIGH      = 16'h8000;
  localparam logic [7:0]  RST_GAIN_LOW       = 8'h00;

  // Field positions
  localparam int POS_LOW_BYTE   = 8;
  localparam int POS_DC_REMOVAL = 0;
  localparam int POS_CH0_DELAY  = 6;
  localparam int POS_CH0_DC_OFF = 2;
  localparam int POS_CH0_INPUT  = 0;

  // Channel 0 input selection
  typedef enum logic [1:0] {
    ACCR_IN_PINS     = 2'h0,
    ACCR_IN_SHORTED  = 2'h1,
    ACCR_IN_TEST_POS = 2'h2,
    ACCR_IN_TEST_NEG = 2'h3
  } accr_input_sel_t;

  // Channel 0 configuration as seen by the datapath
  typedef struct packed {
    logic [9:0]      delay;
    logic            dc_removal_off;
    accr_input_sel_t input_select;
  } accr_channel0_config_t;

  // Combined 24-bit calibration and threshold words
  typedef struct packed {
    logic [23:0] detect_threshold;
    logic [23:0] offset;
    logic [23:0] gain;
  } accr_cal_t;

  // APB request
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } accr_apb_req_t;

  // APB answer
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } accr_apb_rsp_t;

endpackage : accr_pkg

/* rtl/accr_regs.sv */
// Channel threshold, filter and channel 0 calibration register bank on APB
//
// The APB slave port is this design's own decision.
module accr_regs
  import accr_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire accr_pkg::accr_apb_req_t apb_req,
  output accr_pkg::accr_apb_rsp_t      apb_rsp,
  output accr_pkg::accr_channel0_config_t      channel0_config,
  output logic [3:0]                   dc_removal_setting,
  output logic                         ch0_dc_removal_active,
  output accr_pkg::accr_cal_t          cal
);
  import accr_pkg::*;

  // Register map; each 16-bit register sits in the low half of an aligned word
  //   0x1c  threshold upper:  15:0 threshold bits 23:8, two's complement
  //   0x20  threshold lower:  15:8 threshold bits 7:0, 7:4 zero, 3:0 shared setting
  //   0x24  channel 0 config: 15:6 delay, 5:3 zero, 2 filter off, 1:0 input
  //   0x28  offset upper:     15:0 offset bits 23:8, two's complement
  //   0x2c  offset lower:     15:8 offset bits 7:0, 7:0 zero
  //   0x30  gain upper:       15:0 gain bits 23:8, resets to unity gain
  //   0x34  gain lower:       15:8 gain bits 7:0, 7:0 zero
  // Bits 31:16 of every word ignore writes and read zero.
  // Unaligned or unmapped addresses answer with pslverr and change nothing.

  // Bus timing; every access takes exactly one wait state
  //   setup     psel high, penable low; nothing happens yet
  //   access 1  penable high; a write lands, a read word is captured
  //   access 2  pready, prdata and pslverr stand for this cycle only
  // Answer registers clear outside the pulse, so prdata reads zero on an idle bus.
  // Byte strobes act per lane; a field split across lanes takes each part on its own.

  // Stored fields; reserved bits have no storage at all
  logic [15:0]     thr_high_reg;
  logic [7:0]      thr_low_reg;
  logic [3:0]      dc_removal_reg;
  logic [9:0]      delay_reg;
  logic            dc_off_reg;
  logic [1:0]      input_reg;
  logic [15:0]     off_high_reg;
  logic [7:0]      off_low_reg;
  logic [15:0]     gain_high_reg;
  logic [7:0]      gain_low_reg;
  logic            ready_reg;
  logic [31:0]     rdata_reg;
  logic            slverr_reg;
  logic [31:0]     rdata_next;
  logic            hit;
  logic            wr_take;
  logic            rd_take;
  logic [3:0]      idx;
  logic [15:0]     wd;
  logic            access_first;
  logic            lane_hi;
  logic            lane_lo;

  // One write select per register
  logic            sel_thr_high;
  logic            sel_thr_low;
  logic            sel_cfg;
  logic            sel_off_high;
  logic            sel_off_low;
  logic            sel_gain_high;
  logic            sel_gain_low;

  // Index decode: word aligned, inside the small window
  function automatic logic decode_hit(input logic [ADDR_W-1:0] a);
    logic [3:0] i;
    i = a[5:2];
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == '0) &&
           (i >= IDX_THRESHOLD_HIGH) && (i <= IDX_CH0_GAIN_LO);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
    return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Upper register and lower byte joined into one 24-bit quantity
  function automatic logic [23:0] join24(input logic [15:0] upper, input logic [7:0] lower);
    return {upper, lower};
  endfunction

  // Request decode
  assign idx          = apb_req.paddr[5:2];
  assign hit          = decode_hit(apb_req.paddr);
  // First access cycle only; pready high marks the second, so nothing is taken twice
  assign access_first = apb_req.psel && apb_req.penable && !ready_reg;
  assign wr_take      = access_first && apb_req.pwrite && hit;
  assign rd_take      = access_first && !apb_req.pwrite;
  // Upper half of pwdata has no storage behind it
  assign wd           = apb_req.pwdata[15:0];
  assign lane_hi      = apb_req.pstrb[1];
  assign lane_lo      = apb_req.pstrb[0];

  // Write selects, already qualified by a mapped first access cycle
  assign sel_thr_high  = wr_take && (idx == IDX_THRESHOLD_HIGH);
  assign sel_thr_low   = wr_take && (idx == IDX_THRESHOLD_LOW);
  assign sel_cfg       = wr_take && (idx == IDX_CH0_CONFIG);
  assign sel_off_high  = wr_take && (idx == IDX_CH0_OFFSET_HI);
  assign sel_off_low   = wr_take && (idx == IDX_CH0_OFFSET_LO);
  assign sel_gain_high = wr_take && (idx == IDX_CH0_GAIN_HI);
  assign sel_gain_low  = wr_take && (idx == IDX_CH0_GAIN_LO);

  // Threshold upper word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thr_high_reg <= RST_THRESHOLD_HIGH;
    end else if (sel_thr_high) begin
      thr_high_reg <= merge16(thr_high_reg, wd, {lane_hi, lane_lo});
    end
  end

  // Threshold low byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thr_low_reg <= RST_THRESHOLD_LOW;
    end else if (sel_thr_low && lane_hi) begin
      thr_low_reg <= wd[POS_LOW_BYTE +: 8];
    end
  end

  // Shared filter setting; bits 7:4 of this word are reserved and dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dc_removal_reg <= RST_DC_REMOVAL;
    end else if (sel_thr_low && lane_lo) begin
      dc_removal_reg <= wd[POS_DC_REMOVAL +: 4];
    end
  end

  // Channel 0 delay; it straddles both lanes, so each lane writes its own part
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      delay_reg <= RST_CH0_DELAY;
    end else if (sel_cfg) begin
      if (lane_hi) begin
        delay_reg[9:2] <= wd[POS_LOW_BYTE +: 8];
      end
      if (lane_lo) begin
        delay_reg[1:0] <= wd[POS_CH0_DELAY +: 2];
      end
    end
  end

  // Channel 0 filter off bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dc_off_reg <= RST_CH0_DC_OFF;
    end else if (sel_cfg && lane_lo) begin
      dc_off_reg <= wd[POS_CH0_DC_OFF];
    end
  end

  // Channel 0 input selection; all four codes are legal, so none is refused
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      input_reg <= ACCR_IN_PINS;
    end else if (sel_cfg && lane_lo) begin
      input_reg <= wd[POS_CH0_INPUT +: 2];
    end
  end

  // Offset upper word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      off_high_reg <= RST_OFFSET_HIGH;
    end else if (sel_off_high) begin
      off_high_reg <= merge16(off_high_reg, wd, {lane_hi, lane_lo});
    end
  end

  // Offset low byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      off_low_reg <= RST_OFFSET_LOW;
    end else if (sel_off_low && lane_hi) begin
      off_low_reg <= wd[POS_LOW_BYTE +: 8];
    end
  end

  // Gain upper word; reset is unity gain
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gain_high_reg <= RST_GAIN_HIGH;
    end else if (sel_gain_high) begin
      gain_high_reg <= merge16(gain_high_reg, wd, {lane_hi, lane_lo});
    end
  end

  // Gain low byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gain_low_reg <= RST_GAIN_LOW;
    end else if (sel_gain_low && lane_hi) begin
      gain_low_reg <= wd[POS_LOW_BYTE +: 8];
    end
  end

  // Read mux; reserved bits and upper half-word are constant zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (idx)
      IDX_THRESHOLD_HIGH: rdata_next[15:0] = thr_high_reg;
      IDX_THRESHOLD_LOW:  rdata_next[15:0] = {thr_low_reg, 4'h0, dc_removal_reg};
      IDX_CH0_CONFIG:     rdata_next[15:0] = {delay_reg, 3'h0, dc_off_reg, input_reg};
      IDX_CH0_OFFSET_HI:  rdata_next[15:0] = off_high_reg;
      IDX_CH0_OFFSET_LO:  rdata_next[15:0] = {off_low_reg, 8'h00};
      IDX_CH0_GAIN_HI:    rdata_next[15:0] = gain_high_reg;
      IDX_CH0_GAIN_LO:    rdata_next[15:0] = {gain_low_reg, 8'h00};
      default:            rdata_next = 32'h0000_0000;
    endcase
    if (!hit) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // Ready pulse: one wait state, high for one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= access_first;
    end
  end

  // Error flag on unmapped or unaligned address, alongside the ready pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slverr_reg <= 1'b0;
    end else begin
      slverr_reg <= access_first && !hit;
    end
  end

  // Read word; held at zero outside the pulse so an idle bus shows nothing stale
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Channel 0 settings toward the datapath; registered so nothing glitches mid-cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel0_config <= '{delay: RST_CH0_DELAY, dc_removal_off: RST_CH0_DC_OFF,
                   input_select: ACCR_IN_PINS};
    end else begin
      channel0_config.delay          <= delay_reg;
      channel0_config.dc_removal_off <= dc_off_reg;
      channel0_config.input_select   <= accr_input_sel_t'(input_reg);
    end
  end

  // Shared filter setting toward the datapath
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dc_removal_setting <= RST_DC_REMOVAL;
    end else begin
      dc_removal_setting <= dc_removal_reg;
    end
  end

  // Off bit overrides the shared setting; setting zero means no filtering at all
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ch0_dc_removal_active <= 1'b0;
    end else begin
      ch0_dc_removal_active <= !dc_off_reg && (dc_removal_reg != 4'h0);
    end
  end

  // Joined words; a pair written in two accesses shows the first half alone between them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cal <= '{detect_threshold: join24(RST_THRESHOLD_HIGH, RST_THRESHOLD_LOW),
               offset:           join24(RST_OFFSET_HIGH, RST_OFFSET_LOW),
               gain:             join24(RST_GAIN_HIGH, RST_GAIN_LOW)};
    end else begin
      cal.detect_threshold <= join24(thr_high_reg, thr_low_reg);
      cal.offset           <= join24(off_high_reg, off_low_reg);
      cal.gain             <= join24(gain_high_reg, gain_low_reg);
    end
  end

  // Answer to the bus master, straight from the answer registers
  assign apb_rsp = '{pready: ready_reg, prdata: rdata_reg, pslverr: slverr_reg};

endmodule // accr_regs

/* verification/accr_regs_props.sv */
// Checker: APB timing and register-to-output relations of the bank
module accr_regs_props
  import accr_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire accr_apb_req_t apb_req,
  input wire accr_apb_rsp_t apb_rsp,
  input wire accr_channel0_config_t channel0_config,
  input wire logic [3:0]    dc_removal_setting,
  input wire logic          ch0_dc_removal_active,
  input wire accr_cal_t     cal
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic bad;
  // First access cycle, and addresses outside the map
  assign tk = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  assign bad = (apb_req.paddr[1:0] != 2'h0) || (apb_req.paddr[7:2] < 6'h07) ||
               (apb_req.paddr[7:2] > 6'h0d);
  sequence take; tk; endsequence
  sequence wr(a); tk && apb_req.pwrite && apb_req.paddr == a && apb_req.pstrb[1:0] == 2'h3;
  endsequence
  a_one_wait: assert property (take |=> apb_rsp.pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_err_flag: assert property (take |=> apb_rsp.pslverr == $past(bad))
    else $error("pslverr does not match address");
  a_rsv_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_cfg_update: assert property (wr(8'h24) |-> ##3 channel0_config == {$past(apb_req.pwdata[15:6], 3),
    $past(apb_req.pwdata[2:0], 3)}) else $error("channel config not updated");
  a_thr_update: assert property (wr(8'h1c) |-> ##3
    cal.detect_threshold[23:8] == $past(apb_req.pwdata[15:0], 3)) else $error("threshold stale");
  a_thr_low: assert property (wr(8'h20) |-> ##3 {cal.detect_threshold[7:0],
    dc_removal_setting} == $past({apb_req.pwdata[15:8], apb_req.pwdata[3:0]}, 3))
    else $error("threshold low or setting stale");
  a_gain_reset: assert property ($fell(rst) |-> cal.gain == {RST_GAIN_HIGH, RST_GAIN_LOW} &&
    channel0_config == '0)
    else $error("wrong reset value");
  a_active_rule: assert property (ch0_dc_removal_active ==
    (!channel0_config.dc_removal_off && dc_removal_setting != 4'h0)) else $error("filter state wrong");
endmodule // accr_regs_props

bind accr_regs accr_regs_props u_accr_regs_props (.sys_clk(sys_clk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .channel0_config(channel0_config), .cal(cal),
  .dc_removal_setting(dc_removal_setting), .ch0_dc_removal_active(ch0_dc_removal_active));

/* verification/accr_regs_test.sv */
// Bench: APB register accesses against the channel config bank
module accr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import accr_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  accr_apb_req_t req = '0;
  accr_apb_rsp_t rsp;
  accr_channel0_config_t cfg;
  accr_cal_t     cal;
  logic [3:0]    dcs;
  logic          act;
  logic          e;
  logic [31:0]   r;
  int            err_count = 0;
  int            n_compared = 0;
  // Reset values and readable bits, index 7 upwards
  localparam logic [15:0] RV [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
  localparam logic [15:0] MSK [7] = '{16'hffff, 16'hff0f, 16'hffc7, 16'hffff, 16'hff00,
                                      16'hffff, 16'hff00};
  accr_regs u_accr_regs (.sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .channel0_config(cfg), .dc_removal_setting(dcs), .ch0_dc_removal_active(act), .cal(cal));
  // 250 MHz clock
  initial forever #2 sys_clk = ~sys_clk;
  task chk(input logic [71:0] got, input logic [71:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d, 4'hf};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    chk(n < 20, 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task finish_test;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    err_count++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'h1c + 8'(4 * i), 32'h0);
      chk(r, {16'h0, RV[i]});
      apb(1'b1, 8'h1c + 8'(4 * i), 32'hffffffff);
      apb(1'b0, 8'h1c + 8'(4 * i), 32'h0);
      chk(r, {16'h0, MSK[i]});
    end
    chk(cal, {72{1'b1}});
    apb(1'b1, 8'h1c, 32'h1234);
    apb(1'b1, 8'h20, 32'hab05);
    apb(1'b1, 8'h28, 32'h5678);
    apb(1'b1, 8'h2c, 32'hcd00);
    apb(1'b1, 8'h30, 32'h4000);
    apb(1'b1, 8'h34, 32'hef00);
    repeat (3) @(posedge sys_clk);
    chk(cal, {24'h1234ab, 24'h5678cd, 24'h4000ef});
    chk(dcs, 4'h5);
    // Every input selection, with the channel filter switched off
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h24, 32'h8044 | k);
      repeat (3) @(posedge sys_clk);
      chk({cfg, act}, {10'h201, 1'b1, 2'(k), 1'b0});
    end
    apb(1'b1, 8'h24, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(act, 1'b1);
    // Refused accesses leave the map untouched
    apb(1'b0, 8'h00, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, 8'h1d, 32'hffff);
    chk(e, 1'b1);
    apb(1'b0, 8'h1c, 32'h0);
    chk({e, r}, {1'b0, 32'h1234});
    finish_test;
  end
endmodule // accr_regs_test
